// ===== hwmc_pin_board.sv
// Purpose: board-side model of the shared alarm / address / reset-pulse pin
// Assumes: an external resistor sets the level of the released pin
// Notes:   a released pin shows the resistor level, never the last drive
`timescale 1ns/1ps
module hwmc_pin_board (
   input  wire logic drive_i, // value from the device
   input  wire logic oe_n_i,  // low while the device drives
   input  wire logic strap_i, // board resistor level
   output logic      line_o   // resolved pin level
);
   // resolve the open-drain pin against the resistor
   assign line_o = oe_n_i ? strap_i : drive_i;
endmodule : hwmc_pin_board

// ===== hwmc_pkg.sv
// Purpose: shared constants and carriers for the monitor mode configuration slice
// Assumes: 8-bit register access from the internal SMBus slave register port
// Notes:   offsets and field positions are the hardware's; reset values are zero
package hwmc_pkg;
   localparam logic [7:0] DTV_OFFSET       = 8'h4C;
   localparam logic [7:0] MMC_OFFSET       = 8'h4F;
   localparam logic [7:0] DTV_RESET        = 8'h00;
   localparam logic [7:0] MMC_RESET        = 8'h00;
   localparam logic [7:0] VID_RESET        = 8'h00;
   localparam int         MMC_LOWPWR_BIT   = 0;
   localparam int         MMC_CYCLED_BIT   = 1;
   localparam int         MMC_ALARM_EN_BIT = 2;
   localparam int         MMC_VOLT_EN_BIT  = 3;
   localparam int         MMC_OFS_INT_BIT  = 4;
   localparam int         MMC_FAST_AVG_BIT = 5;
   localparam logic [7:0] MMC_WR_MASK      = 8'h3F;
   localparam logic [7:0] MMC_FIXED_ONES   = 8'h00;
   localparam logic [7:0] AVG_REMOTE_SLOW  = 8'h80;
   localparam logic [7:0] AVG_OTHER_SLOW   = 8'h08;
   localparam logic [7:0] AVG_REMOTE_FAST  = 8'h10;
   localparam logic [7:0] AVG_OTHER_FAST   = 8'h01;

   // role of the shared alarm / address / reset-pulse pin
   typedef enum logic [1:0] {HWMC_PIN_ADDR, HWMC_PIN_RSTPULSE, HWMC_PIN_ALARM} hwmc_pin_t;

   // register access request from the SMBus slave
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hwmc_req_t;

   // decoded settings handed to the monitor core
   typedef struct packed {
      logic       shutdown;
      logic       cycled;
      logic       ofs_internal;
      logic [7:0] avg_remote;
      logic [7:0] avg_other;
   } hwmc_cfg_t;
endpackage : hwmc_pkg

// ===== hwmc_regs.sv
// Purpose: digital test value and monitor mode configuration registers
// Assumes: requests are one-cycle strobes synchronous to mclk_i
// Notes:   read data is registered and valid the cycle after rd
`timescale 1ns/1ps

// Notes on behaviour
// (R1) digital test value register is read/write, resets zero, used in digital test
// (R2) config bit 0 selects sleep (0) or shutdown (1) low-power state
// (R3) config bit 1 selects continuous (0) or cycled (1) monitoring
// (R4) config bit 2 set makes shared pin the active-low thermal alarm
// (R5) config bit 2 clear gives pin the address or reset-pulse role
// (R6) config bit 3 set lets out-of-limit voltages pull the alarm low
// (R7) config bit 4 routes temperature offset to external (0) or internal (1)
// (R8) bit 5 clear averages 128 remote-diode and 8 other conversions
// (R9) bit 5 set averages 16 remote-diode conversions, others unaveraged
// (R10) config bits 7:6 are read-only; reserved bits read zero, fixed-one read one
// (R11) voltage-id bit 7 picks address-lsb (0) or reset-pulse (1) pin role
// (R12) writes to reserved config bits are ignored, fixed read values kept
module hwmc_regs (
   input  wire logic              mclk_i,          // 100 MHz clock
   input  wire logic              rstn_i,          // async reset, active low
   input  wire hwmc_pkg::hwmc_req_t req_i,         // register access request
   input  wire logic              vid_rst_en_i,    // voltage-id bit 7
   input  wire logic              temp_alarm_i,    // temperature out of limit
   input  wire logic              volt_alarm_i,    // voltage out/equal limit
   input  wire logic              addr_lsb_i,      // address lsb pin level
   input  wire logic              rst_pulse_i,     // reset pulse request, high
   output logic [7:0]             rdata_o,         // registered read data
   output logic [7:0]             test_value_o,    // digital test value
   output hwmc_pkg::hwmc_cfg_t    cfg_o,           // decoded settings
   output hwmc_pkg::hwmc_pin_t    pin_role_o,      // role of shared pin
   output logic                   pin_o,           // shared pin drive value
   output logic                   pin_oe_n_o,      // low while pin is driven
   output logic                   smbus_addr_lsb_o // captured address lsb
);

   logic [7:0]          dtv_ff;
   logic [7:0]          mmc_ff;
   logic [7:0]          rdata_ff;
   hwmc_pkg::hwmc_cfg_t cfg_ff;
   hwmc_pkg::hwmc_pin_t pin_role_ff;
   hwmc_pkg::hwmc_pin_t nxt_pin_role;
   logic                pin_ff;
   logic                pin_oe_n_ff;
   logic                addr_lsb_ff;
   logic                nxt_alarm;

   // register read view, reserved bits at fixed values
   function automatic logic [7:0] read_view(input logic [7:0] addr,
                                            input logic [7:0] dtv,
                                            input logic [7:0] mmc);
      logic [7:0] v;
      v = 8'h00;
      if (addr == hwmc_pkg::DTV_OFFSET) begin
         v = dtv;
      end else if (addr == hwmc_pkg::MMC_OFFSET) begin
         v = (mmc & hwmc_pkg::MMC_WR_MASK) | hwmc_pkg::MMC_FIXED_ONES;
      end
      return v;
   endfunction : read_view

   // (R1) test value store
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dtv_ff <= hwmc_pkg::DTV_RESET;
      end else if (req_i.wr && req_i.addr == hwmc_pkg::DTV_OFFSET) begin
         dtv_ff <= req_i.wdata;
      end
   end

   // (R12) reserved bits masked
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mmc_ff <= hwmc_pkg::MMC_RESET;
      end else if (req_i.wr && req_i.addr == hwmc_pkg::MMC_OFFSET) begin
         mmc_ff <= req_i.wdata & hwmc_pkg::MMC_WR_MASK;
      end
   end

   // (R10) reserved read values
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= 8'h00;
      end else if (req_i.rd) begin
         rdata_ff <= read_view(req_i.addr, dtv_ff, mmc_ff);
      end
   end

   // (R2) (R3) (R7) decoded mode settings
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_ff <= '0;
      end else begin
         cfg_ff.shutdown     <= mmc_ff[hwmc_pkg::MMC_LOWPWR_BIT];
         cfg_ff.cycled       <= mmc_ff[hwmc_pkg::MMC_CYCLED_BIT];
         cfg_ff.ofs_internal <= mmc_ff[hwmc_pkg::MMC_OFS_INT_BIT];
         // (R8) (R9) averaging counts
         if (mmc_ff[hwmc_pkg::MMC_FAST_AVG_BIT]) begin
            cfg_ff.avg_remote <= hwmc_pkg::AVG_REMOTE_FAST;
            cfg_ff.avg_other  <= hwmc_pkg::AVG_OTHER_FAST;
         end else begin
            cfg_ff.avg_remote <= hwmc_pkg::AVG_REMOTE_SLOW;
            cfg_ff.avg_other  <= hwmc_pkg::AVG_OTHER_SLOW;
         end
      end
   end

   // (R4) (R5) (R11) pin role select
   always_comb begin
      if (mmc_ff[hwmc_pkg::MMC_ALARM_EN_BIT]) begin
         nxt_pin_role = hwmc_pkg::HWMC_PIN_ALARM;
      end else if (vid_rst_en_i) begin
         nxt_pin_role = hwmc_pkg::HWMC_PIN_RSTPULSE;
      end else begin
         nxt_pin_role = hwmc_pkg::HWMC_PIN_ADDR;
      end
   end

   // (R6) voltage contribution gate
   assign nxt_alarm = temp_alarm_i | (volt_alarm_i & mmc_ff[hwmc_pkg::MMC_VOLT_EN_BIT]);

   // shared pin drive, open-drain style low-active outputs
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_role_ff <= hwmc_pkg::HWMC_PIN_ADDR;
         pin_ff      <= 1'b1;
         pin_oe_n_ff <= 1'b1;
         addr_lsb_ff <= 1'b0;
      end else begin
         pin_role_ff <= nxt_pin_role;
         unique case (nxt_pin_role)
            hwmc_pkg::HWMC_PIN_ALARM: begin
               pin_ff      <= ~nxt_alarm;   // active-low alarm
               pin_oe_n_ff <= ~nxt_alarm;
            end
            hwmc_pkg::HWMC_PIN_RSTPULSE: begin
               pin_ff      <= ~rst_pulse_i;
               pin_oe_n_ff <= ~rst_pulse_i;
            end
            hwmc_pkg::HWMC_PIN_ADDR: begin
               pin_ff      <= 1'b1;        // pin is an input
               pin_oe_n_ff <= 1'b1;
               addr_lsb_ff <= addr_lsb_i;
            end
         endcase
      end
   end

   assign rdata_o          = rdata_ff;
   assign test_value_o     = dtv_ff;
   assign cfg_o            = cfg_ff;
   assign pin_role_o       = pin_role_ff;
   assign pin_o            = pin_ff;
   assign pin_oe_n_o       = pin_oe_n_ff;
   assign smbus_addr_lsb_o = addr_lsb_ff;

   // checks
   dtv_store_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R1)
      req_i.wr && req_i.addr == hwmc_pkg::DTV_OFFSET |=> dtv_ff == $past(req_i.wdata))
      else $error("test value not stored");
   lowpwr_map_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R2)
      ##1 cfg_ff.shutdown == $past(mmc_ff[0]))
      else $error("low-power select wrong");
   cycled_map_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R3)
      ##1 cfg_ff.cycled == $past(mmc_ff[1]))
      else $error("monitor mode wrong");
   alarm_role_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R4)
      mmc_ff[2] |=> pin_role_ff == hwmc_pkg::HWMC_PIN_ALARM)
      else $error("alarm role not taken");
   alt_role_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R5)
      rstn_i && !mmc_ff[2] && !vid_rst_en_i |=> pin_role_ff == hwmc_pkg::HWMC_PIN_ADDR)
      else $error("address role not taken");
   volt_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R6)
      mmc_ff[2] && !mmc_ff[3] && !temp_alarm_i |=> pin_oe_n_ff)
      else $error("voltage drove alarm while disabled");
   ofs_route_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R7)
      ##1 cfg_ff.ofs_internal == $past(mmc_ff[4]))
      else $error("offset routing wrong");
   avg_slow_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R8)
      rstn_i && !mmc_ff[5] |=> cfg_ff.avg_remote == hwmc_pkg::AVG_REMOTE_SLOW &&
         cfg_ff.avg_other == hwmc_pkg::AVG_OTHER_SLOW)
      else $error("slow averaging wrong");
   avg_fast_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R9)
      mmc_ff[5] |=> cfg_ff.avg_remote == hwmc_pkg::AVG_REMOTE_FAST &&
         cfg_ff.avg_other == hwmc_pkg::AVG_OTHER_FAST)
      else $error("fast averaging wrong");
   rsvd_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R10)
      req_i.rd && req_i.addr == hwmc_pkg::MMC_OFFSET |=> rdata_ff[7:6] == 2'b00)
      else $error("reserved bits read nonzero");
   rst_role_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R11)
      rstn_i && !mmc_ff[2] && vid_rst_en_i |=> pin_role_ff == hwmc_pkg::HWMC_PIN_RSTPULSE)
      else $error("reset pulse role not taken");
   rsvd_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R12)
      ##1 mmc_ff[7:6] == 2'b00)
      else $error("reserved bits stored");
   alarm_drive_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R4)
      rstn_i && mmc_ff[2] && temp_alarm_i |=> !pin_ff && !pin_oe_n_ff)
      else $error("temperature alarm not driven low");
   volt_drive_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R6)
      mmc_ff[2] && mmc_ff[3] && volt_alarm_i |=> !pin_ff && !pin_oe_n_ff)
      else $error("enabled voltage alarm not driven low");
   pulse_drive_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R11)
      rstn_i && !mmc_ff[2] && vid_rst_en_i && rst_pulse_i |=> !pin_ff && !pin_oe_n_ff)
      else $error("reset pulse not driven low");
   dtv_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R1)
      req_i.rd && req_i.addr == hwmc_pkg::DTV_OFFSET |=> rdata_ff == $past(dtv_ff))
      else $error("test value read wrong");
   addr_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // (R5)
      nxt_pin_role != hwmc_pkg::HWMC_PIN_ADDR |=> addr_lsb_ff == $past(addr_lsb_ff))
      else $error("address lsb changed outside address role");
   // cover points for the main scenarios
   cfg_write_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      req_i.wr && req_i.addr == hwmc_pkg::MMC_OFFSET ##1 mmc_ff[2]);
   alarm_low_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      pin_role_ff == hwmc_pkg::HWMC_PIN_ALARM && !pin_oe_n_ff);
   fast_avg_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      cfg_ff.avg_remote == hwmc_pkg::AVG_REMOTE_FAST);
   rst_pulse_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      pin_role_ff == hwmc_pkg::HWMC_PIN_RSTPULSE && !pin_oe_n_ff);
   volt_alarm_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      mmc_ff[3] && mmc_ff[2] && volt_alarm_i ##1 !pin_oe_n_ff);

endmodule : hwmc_regs

// ===== tb_hw_monitor_mode_config.sv
// Purpose: register and pin checks of the monitor mode configuration slice
// Assumes: one-cycle request strobes, read data one cycle after rd
// Notes:   inputs change at rising edges by non-blocking assignment
`timescale 1ns/1ps
module tb_hw_monitor_mode_config;
   logic                mclk_i = 1'b0;
   logic                rstn_i = 1'b0;
   hwmc_pkg::hwmc_req_t req    = '0;
   logic                vid_en = 1'b0, t_alm = 1'b0, v_alm = 1'b0;
   logic                rpls   = 1'b0, strap = 1'b0;
   logic                line, pin, pin_oe_n, lsb;
   logic [7:0]          rdata, tval;
   hwmc_pkg::hwmc_cfg_t cfg;
   hwmc_pkg::hwmc_pin_t role;
   int                  mismatches = 0;
   int                  checked    = 0;

   hwmc_regs u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req), .vid_rst_en_i(vid_en),
      .temp_alarm_i(t_alm), .volt_alarm_i(v_alm), .addr_lsb_i(line), .rst_pulse_i(rpls),
      .rdata_o(rdata), .test_value_o(tval), .cfg_o(cfg), .pin_role_o(role), .pin_o(pin),
      .pin_oe_n_o(pin_oe_n), .smbus_addr_lsb_o(lsb));
   hwmc_pin_board u_board (.drive_i(pin), .oe_n_i(pin_oe_n), .strap_i(strap), .line_o(line));

   // free-running 100 MHz clock
   always #5 mclk_i = ~mclk_i;

   task automatic close_out();
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   task automatic chk(input logic [18:0] got, input logic [18:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i) req <= {1'b1, 1'b0, a, d};
      @(posedge mclk_i) req <= '0;
      tick(2);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i) req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge mclk_i) req <= '0;
      #1 chk(rdata, exp);
   endtask : rd

   // hang guard
   initial begin
      #50us;
      mismatches++;
      close_out();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rd(8'h4C, 8'h00);
      rd(8'h4F, 8'h00);
      rd(8'h4D, 8'h00);
      chk(cfg, {3'b000, 8'h80, 8'h08});
      // address role leaves the pin released even with an alarm
      @(posedge mclk_i) t_alm <= 1'b1;
      strap <= 1'b1;
      tick(3);
      chk({role, pin_oe_n}, {hwmc_pkg::HWMC_PIN_ADDR, 1'b1});
      chk(lsb, 1'b1);
      wr(8'h4C, 8'hA5);
      rd(8'h4C, 8'hA5);
      chk(tval, 8'hA5);
      @(posedge mclk_i) t_alm <= 1'b0;
      wr(8'h4F, 8'hFF);
      rd(8'h4F, 8'h3F);
      chk(cfg, {3'b111, 8'h10, 8'h01});
      // one configuration bit at a time
      for (int b = 0; b < 6; b++) begin
         wr(8'h4F, 8'h01 << b);
         chk(cfg, {b == 0, b == 1, b == 4, (b == 5) ? 16'h1001 : 16'h8008});
         chk(role, (b == 2) ? hwmc_pkg::HWMC_PIN_ALARM : hwmc_pkg::HWMC_PIN_ADDR);
      end
      // alarm pin: temperature always, voltage only when enabled
      wr(8'h4F, 8'h04);
      chk({pin_oe_n, line}, 2'b11);
      @(posedge mclk_i) t_alm <= 1'b1;
      tick(2);
      chk({pin_oe_n, line}, 2'b00);
      @(posedge mclk_i) t_alm <= 1'b0;
      v_alm <= 1'b1;
      tick(2);
      chk({pin_oe_n, line}, 2'b11);
      wr(8'h4F, 8'h0C);
      chk({pin_oe_n, line}, 2'b00);
      // reset-pulse role chosen by voltage-id bit 7
      wr(8'h4F, 8'h08);
      @(posedge mclk_i) vid_en <= 1'b1;
      tick(2);
      chk({role, pin_oe_n}, {hwmc_pkg::HWMC_PIN_RSTPULSE, 1'b1});
      @(posedge mclk_i) rpls <= 1'b1;
      tick(2);
      chk({pin_oe_n, line}, 2'b00);
      @(posedge mclk_i) rpls <= 1'b0;
      v_alm <= 1'b0;
      tick(2);
      chk({pin_oe_n, line}, 2'b11);
      // address lsb held outside the address role, sampled again inside it
      @(posedge mclk_i) strap <= 1'b0;
      tick(2);
      chk(lsb, 1'b1);
      @(posedge mclk_i) vid_en <= 1'b0;
      tick(2);
      chk({role, lsb}, {hwmc_pkg::HWMC_PIN_ADDR, 1'b0});
      // reset in mid-run brings registers and outputs back to reset values
      wr(8'h4C, 8'h5A);
      wr(8'h4F, 8'h3F);
      rd(8'h4F, 8'h3F);
      @(posedge mclk_i) rstn_i <= 1'b0;
      tick(2);
      chk({rdata, tval, lsb}, 17'h00000);
      chk(cfg, 19'h00000);
      chk({role, pin_oe_n}, {hwmc_pkg::HWMC_PIN_ADDR, 1'b1});
      @(posedge mclk_i) rstn_i <= 1'b1;
      rd(8'h4C, 8'h00);
      rd(8'h4F, 8'h00);
      chk(cfg, {3'b000, 8'h80, 8'h08});
      close_out();
   end
endmodule : tb_hw_monitor_mode_config
